// ### hdl/ppio_pkg.sv
package ppio_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFF_B_IN = 8'h01;
  localparam logic [7:0] OFF_A_OUT = 8'h04;
  localparam logic [7:0] OFF_B_OUT = 8'h05;
  localparam logic [7:0] OFF_A_DIR = 8'h06;
  localparam logic [7:0] OFF_B_DIR = 8'h07;
  localparam logic [7:0] OFF_C_IN = 8'h10;
  localparam logic [7:0] OFF_D_IN = 8'h11;
  localparam logic [7:0] OFF_C_OUT = 8'h12;
  localparam logic [7:0] OFF_D_OUT = 8'h13;
  localparam logic [7:0] OFF_C_DIR = 8'h14;
  localparam logic [7:0] OFF_D_DIR = 8'h15;
  // Value of registers after reset
  localparam logic [7:0] RST_VAL = 8'h00;
  // Implemented pin positions on ports C and D
  localparam logic [7:0] C_MASK = 8'h9c;
  localparam logic [7:0] D_MASK = 8'h06;
  // Answer to unmapped reads and to unimplemented bits
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
endpackage

// ### hdl/ppio_port.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ns
// Function
// RL1 - Input bit reads current pin level; only ports B-D have an input register, port A has none
// RL2 - Output bit drives pin level
// RL3 - Output registers clear at reset
// RL4 - Direction one is output, zero input
// RL5 - Direction registers clear at reset
// RL6 - Unimplemented C/D input bits undefined
// RL7 - Port C/D registers at fixed offsets
// RL8 - Ports A-C inputs through input macrocells
// RL9 - Array outputs drive A-C, chip selects D
// RL10 - Array output pins exclude other modes
// RL11 - Array input pins stay readable, directable
// RL12 - Output bit ignored on array output
// RL13 - Buffer enable is array oe OR direction
// RL14 - Pins start as high-impedance inputs
// RL15 - Array oe alone makes pin output
// RL16 - Internal-only macrocell leaves pin free
// RL17 - Writable registers read back; inputs ignore writes
module ppio_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins, index 0 port A .. 3 port D
  input wire logic [7:0] pin_in [4],
  output logic [7:0] pin_out [4],
  output logic [7:0] pin_oe [4],
  // Logic array side: per pin routing select, value and enable
  input wire logic [7:0] array_out_sel [4],
  input wire logic [7:0] array_out_val [4],
  input wire logic [7:0] array_oe [4],
  output logic [7:0] array_in_bus [4]
);

  logic [7:0] sync1_q [4];
  logic [7:0] sync2_q [4];
  logic [7:0] in_cell_q [3];
  logic [7:0] out_q [4];
  logic [7:0] dir_q [4];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [2:0] oidx;
  logic [2:0] didx;

  // Port index of a data-out offset, or 4 for none
  function automatic logic [2:0] out_idx(input logic [7:0] a);
    unique case (a)
      ppio_pkg::OFF_A_OUT: out_idx = 3'h0;
      ppio_pkg::OFF_B_OUT: out_idx = 3'h1;
      ppio_pkg::OFF_C_OUT: out_idx = 3'h2;
      ppio_pkg::OFF_D_OUT: out_idx = 3'h3;
      default: out_idx = 3'h4;
    endcase
  endfunction

  function automatic logic [2:0] dir_idx(input logic [7:0] a);
    unique case (a)
      ppio_pkg::OFF_A_DIR: dir_idx = 3'h0;
      ppio_pkg::OFF_B_DIR: dir_idx = 3'h1;
      ppio_pkg::OFF_C_DIR: dir_idx = 3'h2;
      ppio_pkg::OFF_D_DIR: dir_idx = 3'h3;
      default: dir_idx = 3'h4;
    endcase
  endfunction

  // Decoded register indices, 4 when the offset is not of that kind
  assign oidx = out_idx(reg_addr);
  assign didx = dir_idx(reg_addr);

  // Two-stage synchronisers on every pin
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < 4; p++) begin
      sync1_q[p] <= pin_in[p];
      sync2_q[p] <= sync1_q[p];
    end
  end

  // RL8 input macrocells on A-C
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int p = 0; p < 3; p++) begin
        in_cell_q[p] <= ppio_pkg::RST_VAL;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        in_cell_q[p] <= sync2_q[p];
      end
    end
  end

  // RL8 port D feeds bus directly
  always_comb begin
    array_in_bus[0] = in_cell_q[0];
    array_in_bus[1] = in_cell_q[1];
    array_in_bus[2] = in_cell_q[2];
    array_in_bus[3] = sync2_q[3];
  end

  // RL3 RL17 output value registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int p = 0; p < 4; p++) begin
        out_q[p] <= ppio_pkg::RST_VAL;
      end
    end else if (reg_wr && oidx != 3'h4) begin
      out_q[oidx[1:0]] <= reg_wdata;
    end
  end

  // RL5 RL14 direction registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int p = 0; p < 4; p++) begin
        dir_q[p] <= ppio_pkg::RST_VAL;
      end
    end else if (reg_wr && didx != 3'h4) begin
      dir_q[didx[1:0]] <= reg_wdata;
    end
  end

  // RL1 RL7 RL6 RL11 read decode
  always_comb begin
    rdata_d = ppio_pkg::UNMAPPED_VAL;
    if (oidx != 3'h4) begin
      rdata_d = out_q[oidx[1:0]];
    end else if (didx != 3'h4) begin
      rdata_d = dir_q[didx[1:0]];
    end else if (reg_addr == ppio_pkg::OFF_B_IN) begin
      rdata_d = sync2_q[1];
    end else if (reg_addr == ppio_pkg::OFF_C_IN) begin
      rdata_d = sync2_q[2] & ppio_pkg::C_MASK;
    end else if (reg_addr == ppio_pkg::OFF_D_IN) begin
      rdata_d = sync2_q[3] & ppio_pkg::D_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_q <= ppio_pkg::RST_VAL;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= ppio_pkg::RST_VAL;
    end
  end

  assign reg_rdata = rdata_q;

  // Output stage per port
  for (genvar p = 0; p < 4; p++) begin : g_pin
    // RL2 RL9 RL10 RL12 RL16 array output overrides register
    assign pin_out[p] = (array_out_sel[p] & array_out_val[p]) |
                        (~array_out_sel[p] & out_q[p]);
    // RL4 RL13 RL15 enable is OR of array oe and direction
    assign pin_oe[p] = array_oe[p] | dir_q[p];
  end

  // RL13 enable follows direction or array oe
  pin_oe_or_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_oe[1] == (array_oe[1] | dir_q[1]))
    else $error("pin enable not OR of array oe and direction");
  // RL12 array output ignores register
  arr_out_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    array_out_sel[0][0] |-> pin_out[0][0] == array_out_val[0][0])
    else $error("array output pin not driven from array");
  // RL2 register drives pin
  reg_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_B_OUT && !array_out_sel[1][3]
    |=> pin_out[1][3] == $past(reg_wdata[3]))
    else $error("output bit did not reach pin");
  // RL17 direction read back
  dir_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_C_DIR ##1
    reg_rd && reg_addr == ppio_pkg::OFF_C_DIR && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("direction register read back wrong");
  // RL3 RL5 clear after reset
  reset_clear_a: assert property (@(posedge clk_sys)
    !rst_b |=> out_q[3] == 8'h00 && dir_q[0] == 8'h00)
    else $error("registers not cleared by reset");
  // RL1 input read shows pin
  in_level_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == ppio_pkg::OFF_B_IN |=> reg_rdata == $past(sync2_q[1]))
    else $error("input register not pin level");
  // RL14 pins start as inputs
  pwr_input_a: assert property (@(posedge clk_sys)
    $rose(rst_b) && array_oe[2] == 8'h00 |-> pin_oe[2] == 8'h00)
    else $error("pin enabled after reset without array oe");
  // RL8 port D goes straight to bus
  d_direct_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |->
    array_in_bus[3] == sync2_q[3] && array_in_bus[0] == $past(sync2_q[0]))
    else $error("array input path wrong");

  // RL13 port A enable
  oe_port_a_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_oe[0] == (array_oe[0] | dir_q[0]))
    else $error("port A enable not OR of array oe and direction");

  // RL13 port C enable
  oe_port_c_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_oe[2] == (array_oe[2] | dir_q[2]))
    else $error("port C enable not OR of array oe and direction");

  // RL13 port D enable
  oe_port_d_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_oe[3] == (array_oe[3] | dir_q[3]))
    else $error("port D enable not OR of array oe and direction");

  // RL2 RL12 port A pin value
  mix_port_a_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_out[0] == ((array_out_sel[0] & array_out_val[0]) |
                   (~array_out_sel[0] & out_q[0])))
    else $error("port A pin value wrong");

  // RL2 RL12 port C pin value
  mix_port_c_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_out[2] == ((array_out_sel[2] & array_out_val[2]) |
                   (~array_out_sel[2] & out_q[2])))
    else $error("port C pin value wrong");

  // RL9 chip select on port D
  d_chip_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    array_out_sel[3][1] |-> pin_out[3][1] == array_out_val[3][1])
    else $error("port D pin not driven by chip select");

  // RL10 RL12 whole port from array
  arr_whole_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    array_out_sel[1] == 8'hff |-> pin_out[1] == array_out_val[1])
    else $error("array port still follows register");

  // RL16 unselected pin stays free
  node_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !array_out_sel[1][5] |-> pin_out[1][5] == out_q[1][5])
    else $error("unselected pin not under register");

  // RL15 array oe alone drives pin
  oe_alone_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    array_oe[1][0] |-> pin_oe[1][0])
    else $error("array oe did not enable pin");

  // RL14 inputs without oe or direction
  d_input_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dir_q[3] == 8'h00 && array_oe[3] == 8'h00 |-> pin_oe[3] == 8'h00)
    else $error("port D driven with no enable source");

  // RL4 RL11 direction bit enables pin
  dir_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dir_q[1][4] |-> pin_oe[1][4])
    else $error("direction bit did not enable pin");

  // RL17 idle read data
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared after read");

  // RL17 output register read back
  out_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == ppio_pkg::OFF_A_OUT |=> reg_rdata == $past(out_q[0]))
    else $error("port A output register read wrong");

  // RL17 direction register read back
  dir_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == ppio_pkg::OFF_D_DIR |=> reg_rdata == $past(dir_q[3]))
    else $error("port D direction register read wrong");

  // RL1 RL6 port C input read
  in_c_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == ppio_pkg::OFF_C_IN |=>
    (reg_rdata & ppio_pkg::C_MASK) == ($past(sync2_q[2]) & ppio_pkg::C_MASK))
    else $error("port C input register not pin level");

  // RL1 RL6 port D input read
  in_d_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == ppio_pkg::OFF_D_IN |=>
    (reg_rdata & ppio_pkg::D_MASK) == ($past(sync2_q[3]) & ppio_pkg::D_MASK))
    else $error("port D input register not pin level");

  // RL7 unmapped reads
  unmapped_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == 8'h20 |=> reg_rdata == ppio_pkg::UNMAPPED_VAL)
    else $error("unmapped read not default value");

  // RL17 input writes ignored
  in_wr_ign_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_B_IN |=>
    out_q[1] == $past(out_q[1]) && dir_q[1] == $past(dir_q[1]) &&
    out_q[0] == $past(out_q[0]) && dir_q[0] == $past(dir_q[0]))
    else $error("write to input register changed state");

  // RL2 port A output write
  out_wr_a_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_A_OUT |=> out_q[0] == $past(reg_wdata))
    else $error("port A output write lost");

  // RL2 port C output write
  out_wr_c_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_C_OUT |=> out_q[2] == $past(reg_wdata))
    else $error("port C output write lost");

  // RL2 port D output write
  out_wr_d_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_D_OUT |=> out_q[3] == $past(reg_wdata))
    else $error("port D output write lost");

  // RL4 port A direction write
  dir_wr_a_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_A_DIR |=> dir_q[0] == $past(reg_wdata))
    else $error("port A direction write lost");

  // RL4 port B direction write
  dir_wr_b_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_B_DIR |=> dir_q[1] == $past(reg_wdata))
    else $error("port B direction write lost");

  // RL4 port D direction write
  dir_wr_d_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == ppio_pkg::OFF_D_DIR |=> dir_q[3] == $past(reg_wdata))
    else $error("port D direction write lost");

  // RL8 port B through input macrocell
  in_cell_b_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> array_in_bus[1] == $past(sync2_q[1]))
    else $error("port B array input not through macrocell");

  // RL1 pin level reaches read path
  sync_path_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b, 2) |-> sync2_q[1] == $past(pin_in[1], 2))
    else $error("pin level lost in synchroniser");

endmodule

// ### testbench/ppio_board.sv
`timescale 1ns/1ns
module ppio_board (
  // Device side
  input wire logic [7:0] pin_out [4],
  input wire logic [7:0] pin_oe [4],
  // Board side
  input wire logic [7:0] bval [4],
  output logic [7:0] pin_in [4]
);
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_in[p] = (pin_out[p] & pin_oe[p]) | (bval[p] & ~pin_oe[p]);
    end
  end
endmodule

// ### testbench/test_pld_port_pin_io.sv
`timescale 1ns/1ns
module test_pld_port_pin_io;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] pin_in [4], pin_out [4], pin_oe [4], ain [4];
  logic [7:0] sel [4], val [4], aoe [4], bval [4];
  logic [7:0] oo [4] = '{8'h04, 8'h05, 8'h12, 8'h13};
  logic [7:0] dd [4] = '{8'h06, 8'h07, 8'h14, 8'h15};
  int fail_count = 0;
  int samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  ppio_port ppio_port_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .array_out_sel(sel),
    .array_out_val(val), .array_oe(aoe), .array_in_bus(ain));
  ppio_board ppio_board_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .bval(bval), .pin_in(pin_in));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), e & m, reg_rdata & m);
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    conclude;
  end
  initial begin
    for (int p = 0; p < 4; p++) begin
      sel[p] = 8'h00;
      val[p] = 8'h00;
      aoe[p] = 8'h00;
      bval[p] = 8'h00;
    end
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      rd(oo[p], 8'h00, 8'hff);
      rd(dd[p], 8'h00, 8'hff);
      chk("oe", 8'h00, pin_oe[p]);
    end
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wr(oo[p], 8'h3c + p[7:0]);
      wr(dd[p], 8'hc3 - p[7:0]);
      chk("out", 8'h3c + p[7:0], pin_out[p]);
      chk("oe", 8'hc3 - p[7:0], pin_oe[p]);
      rd(oo[p], 8'h3c + p[7:0], 8'hff);
      rd(dd[p], 8'hc3 - p[7:0], 8'hff);
    end
    $display("test registers done");
    @(posedge clk_sys);
    for (int p = 0; p < 4; p++) bval[p] <= 8'h96 ^ p[7:0];
    for (int p = 0; p < 4; p++) wr(dd[p], 8'h00);
    wr(8'h01, 8'h00);
    repeat (4) @(posedge clk_sys);
    #1;
    rd(8'h01, 8'h97, 8'hff);
    rd(8'h10, 8'h94, ppio_pkg::C_MASK);
    rd(8'h11, 8'h95, ppio_pkg::D_MASK);
    rd(8'h20, ppio_pkg::UNMAPPED_VAL, 8'hff);
    for (int p = 0; p < 4; p++) chk("ain", 8'h96 ^ p[7:0], ain[p]);
    $display("test inputs done");
    @(posedge clk_sys);
    sel[1] <= 8'hff;
    val[1] <= 8'ha5;
    aoe[1] <= 8'h0f;
    sel[3] <= 8'h06;
    val[3] <= 8'h02;
    wr(8'h07, 8'hf0);
    wr(8'h05, 8'h5a);
    chk("out", 8'ha5, pin_out[1]);
    chk("oe", 8'hff, pin_oe[1]);
    chk("out", 8'h3b, pin_out[3]);
    wr(8'h07, 8'h00);
    chk("oe", 8'h0f, pin_oe[1]);
    rd(8'h05, 8'h5a, 8'hff);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= 8'h14;
    reg_wdata <= 8'h84;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("dir back", 8'h84, reg_rdata);
    $display("test array done");
    conclude;
  end
endmodule
